/* logic/pgm_cfg.svh */
// register offsets, field positions, reset values and constants of the panel mapper
`ifndef PGM_CFG_SVH
`define PGM_CFG_SVH
`define PGM_OFF_CTRL   8'h00
`define PGM_OFF_POL    8'h04
`define PGM_OFF_HTIM   8'h08
`define PGM_OFF_VTIM   8'h0C
`define PGM_OFF_LUT    8'h10
`define PGM_OFF_STAT   8'h14
`define PGM_C_EN       0
`define PGM_C_COLOR    1
`define PGM_C_PWM      2
`define PGM_C_HIC      3
`define PGM_C_565      4
`define PGM_C_PWROFF   5
`define PGM_C_IDLE     6
`define PGM_C_ROUND    7
`define PGM_C_TRUNC    8
`define PGM_C_WID      10:9
`define PGM_C_DIV      15:12
`define PGM_P_TOG      0
`define PGM_P_FRM      1
`define PGM_P_LINE     2
`define PGM_P_SCLK     3
`define PGM_P_DE       4
`define PGM_F_ACT      11:0
`define PGM_F_TOT      27:16
`define PGM_L_IDX      7:0
`define PGM_L_SEL      9:8
`define PGM_L_DAT      21:16
`define PGM_SEL_SHADE  2'h3
`define PGM_HTIM_RST   32'h0320_0280
`define PGM_VTIM_RST   32'h020D_01E0
`define PGM_RESP_OK    2'h0
`define PGM_RESP_ERR   2'h2
`define PGM_W_RED      8'h4D
`define PGM_W_GRN      8'h97
`define PGM_W_BLU      8'h1C
`define PGM_STN_LAST   3'h7
`define PGM_RND_ADD    7'h02
`define PGM_FIFO_W     16
`define PGM_FIFO_D     4
`endif

/* logic/pgm_pkg.sv */
// types of the panel gray and color mapper
package pgm_pkg;
    typedef enum logic [6:0] {
        PGM_REG_NONE = 7'h01,
        PGM_REG_CTRL = 7'h02,
        PGM_REG_POL  = 7'h04,
        PGM_REG_HTIM = 7'h08,
        PGM_REG_VTIM = 7'h10,
        PGM_REG_LUT  = 7'h20,
        PGM_REG_STAT = 7'h40
    } pgm_reg_t;

    typedef struct packed {
        logic [31:0] ctrl;
        logic [4:0]  pol;
        logic [31:0] htim;
        logic [31:0] vtim;
        logic        lut_we;
        logic [1:0]  lut_sel;
        logic [7:0]  lut_idx;
        logic [5:0]  lut_dat;
        logic        aw_ok;
        logic [7:0]  awaddr;
        logic        w_ok;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [1:0]  rresp;
        logic [31:0] rdata;
        logic [3:0]  div;
        logic [11:0] hcnt;
        logic [11:0] vcnt;
        logic [1:0]  phase;
        logic        tog;
        logic        v0, de0, line0, frm0;
        logic [1:0]  x0, y0;
        logic [15:0] pix0;
        logic        v1, de1, line1, frm1;
        logic [1:0]  x1, y1;
        logic [17:0] hc1;
        logic        v2, de2, line2, frm2;
        logic [1:0]  x2, y2;
        logic [5:0]  r2, g2, b2, i2;
        logic [7:0]  sr;
        logic [2:0]  scnt;
        logic        de_a;
        logic [17:0] dout;
        logic        sclk_q, line_q, frm_q, de_q, tog_q;
        logic [5:0]  dac_r, dac_g, dac_b;
    } pgm_state_t;
endpackage : pgm_pkg

/* logic/pgm_store.sv */
// pixel fifo and small registered-read memory of the panel mapper
`timescale 1ns/1ps
module pgm_fifo #(
    parameter int W = 16,
    parameter int D = 4
) (
    // clock and reset
    input  wire logic         mclk_i,
    input  wire logic         nrst_i,
    // filling side
    input  wire logic [W-1:0] in_data_i,
    input  wire logic         in_valid_i,
    output logic              in_ready_o,
    // draining side
    output logic [W-1:0]      out_data_o,
    output logic              out_valid_o,
    input  wire logic         out_ready_i
);
    localparam int AW = $clog2(D);
    logic [W-1:0]  mem [D];
    logic [AW-1:0] wp, rp;
    logic [AW:0]   cnt;
    logic          push, pop;

    assign in_ready_o  = (cnt != (AW+1)'(D));
    assign out_valid_o = (cnt != '0);
    assign out_data_o  = mem[rp];
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;

    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            wp  <= '0;
            rp  <= '0;
            cnt <= '0;
        end else begin
            if (push) begin
                mem[wp] <= in_data_i;
                wp      <= wp + 1'b1;
            end
            if (pop) begin
                rp <= rp + 1'b1;
            end
            cnt <= cnt + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule : pgm_fifo

module pgm_ram #(
    parameter int AW = 8,
    parameter int DW = 6
) (
    // clock and reset
    input  wire logic          mclk_i,
    input  wire logic          nrst_i,
    // write port
    input  wire logic          we_i,
    input  wire logic [AW-1:0] waddr_i,
    input  wire logic [DW-1:0] wdata_i,
    // registered read port
    input  wire logic          re_i,
    input  wire logic [AW-1:0] raddr_i,
    output logic [DW-1:0]      rdata_o
);
    logic [DW-1:0] mem [2**AW];

    always_ff @(posedge mclk_i) begin
        if (we_i) begin
            mem[waddr_i] <= wdata_i;
        end
        if (!nrst_i) begin
            rdata_o <= '0;
        end else if (re_i) begin
            rdata_o <= mem[raddr_i];
        end
    end
endmodule : pgm_ram

/* logic/pgm_mapper.sv */
// panel gray and color mapper: lookup, weighting, shading, dithering, panel strobes
`timescale 1ns/1ps
`include "pgm_cfg.svh"

// Behaviour
// - gray intensity is 0.3R+0.59G+0.11B
// - frame-rate mono: intensity indexes 64-entry shade map
// - pulse-width mono: truncated or rounded intensity forwarded
// - color frame-rate: components go through dithering
// - color pulse-width: components passed whole or truncated
// - 64 shades from spatial pattern plus frame phase
// - three 256x6 lookup tables feed 6-bit converters
// - high color splits 5-6-5 or 5-5-5
// - high color bypasses the lookup tables
// - 5-bit colors get converter lsb forced zero
// - panel strobes with programmable timing and polarity
// - panel path starts at lookup output
// - idle: outputs off, registers served, pixels refused
// - power-off bit drives panel pins off
// - mono STN: 8 pixels per shift clock
// - TFT: one pixel per clock, 9/12/18 bits
module pgm_mapper (
    // clock and reset
    input  wire logic        mclk_i,
    input  wire logic        nrst_i,
    // axi4-lite write
    input  wire logic [7:0]  s_axi_awaddr_i,
    input  wire logic        s_axi_awvalid_i,
    output logic             s_axi_awready_o,
    input  wire logic [31:0] s_axi_wdata_i,
    input  wire logic [3:0]  s_axi_wstrb_i,
    input  wire logic        s_axi_wvalid_i,
    output logic             s_axi_wready_o,
    output logic [1:0]       s_axi_bresp_o,
    output logic             s_axi_bvalid_o,
    input  wire logic        s_axi_bready_i,
    // axi4-lite read
    input  wire logic [7:0]  s_axi_araddr_i,
    input  wire logic        s_axi_arvalid_i,
    output logic             s_axi_arready_o,
    output logic [31:0]      s_axi_rdata_o,
    output logic [1:0]       s_axi_rresp_o,
    output logic             s_axi_rvalid_o,
    input  wire logic        s_axi_rready_i,
    // pixel stream
    input  wire logic [15:0] pix_data_i,
    input  wire logic        pix_valid_i,
    output logic             pix_ready_o,
    // panel pins
    output logic             panel_frame_toggle_o,
    output logic             panel_frame_start_pulse_o,
    output logic             panel_line_latch_pulse_o,
    output logic             panel_shift_clock_o,
    output logic             panel_data_enable_o,
    output logic [7:0]       upper_panel_data_o,
    output logic [7:0]       lower_panel_data_o,
    output logic [1:0]       panel_extra_data_o,
    // converter inputs
    output logic [5:0]       dac_red_o,
    output logic [5:0]       dac_green_o,
    output logic [5:0]       dac_blue_o
);
    // ==========================================================
    // functions
    function automatic pgm_pkg::pgm_reg_t reg_dec(input logic [7:0] a);
        case (a)
            `PGM_OFF_CTRL: reg_dec = pgm_pkg::PGM_REG_CTRL;
            `PGM_OFF_POL:  reg_dec = pgm_pkg::PGM_REG_POL;
            `PGM_OFF_HTIM: reg_dec = pgm_pkg::PGM_REG_HTIM;
            `PGM_OFF_VTIM: reg_dec = pgm_pkg::PGM_REG_VTIM;
            `PGM_OFF_LUT:  reg_dec = pgm_pkg::PGM_REG_LUT;
            `PGM_OFF_STAT: reg_dec = pgm_pkg::PGM_REG_STAT;
            default:       reg_dec = pgm_pkg::PGM_REG_NONE;
        endcase
    endfunction : reg_dec

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                          input logic [3:0] st);
        merge = old;
        for (int k = 0; k < 4; k++) begin
            if (st[k]) begin
                merge[k*8 +: 8] = wd[k*8 +: 8];
            end
        end
    endfunction : merge

    // fixed-point weights sum to 256, top six bits kept
    function automatic logic [5:0] weigh(input logic [17:0] c);
        logic [15:0] sum;
        sum = 16'(c[5:0] * `PGM_W_RED) + 16'(c[11:6] * `PGM_W_GRN)
            + 16'(c[17:12] * `PGM_W_BLU);
        weigh = sum[13:8];
    endfunction : weigh

    // ordered threshold: 16 spatial levels times 4 frame phases
    function automatic logic dith(input logic [5:0] v, input logic [1:0] x,
                                  input logic [1:0] y, input logic [1:0] ph);
        logic [3:0] b;
        case ({y, x})
            4'h0: b = 4'h0;  4'h1: b = 4'h8;  4'h2: b = 4'h2;  4'h3: b = 4'hA;
            4'h4: b = 4'hC;  4'h5: b = 4'h4;  4'h6: b = 4'hE;  4'h7: b = 4'h6;
            4'h8: b = 4'h3;  4'h9: b = 4'hB;  4'hA: b = 4'h1;  4'hB: b = 4'h9;
            4'hC: b = 4'hF;  4'hD: b = 4'h7;  4'hE: b = 4'hD;  default: b = 4'h5;
        endcase
        // phase rotated by position so neighbours never flip together
        dith = v > {b, ph + x};
    endfunction : dith

    function automatic logic [17:0] fmt(input logic [5:0] r, input logic [5:0] g,
                                        input logic [5:0] b, input logic [1:0] w);
        case (w)
            2'h1:    fmt = {6'h00, b[5:2], g[5:2], r[5:2]};
            2'h2:    fmt = {9'h000, b[5:3], g[5:3], r[5:3]};
            default: fmt = {b, g, r};
        endcase
    endfunction : fmt

    // ==========================================================
    // state and storage
    pgm_pkg::pgm_state_t s, n;
    logic [15:0] f_data;
    logic        f_valid;
    logic        f_in_ready;
    logic        pop;
    logic        tick;
    logic [5:0]  lut_q [3];
    logic [5:0]  shade_q;
    logic [5:0]  int1;
    logic [17:0] rgb1;

    pgm_fifo #(
        .W (`PGM_FIFO_W),
        .D (`PGM_FIFO_D)
    ) u_fifo (
        .mclk_i      (mclk_i),
        .nrst_i      (nrst_i),
        .in_data_i   (pix_data_i),
        .in_valid_i  (pix_valid_i && !s.ctrl[`PGM_C_IDLE]),
        .in_ready_o  (f_in_ready),
        .out_data_o  (f_data),
        .out_valid_o (f_valid),
        .out_ready_i (pop)
    );

    // idle mode stops pixel fetch but keeps the register bus alive
    assign pix_ready_o = f_in_ready && !s.ctrl[`PGM_C_IDLE];

    for (genvar gi = 0; gi < 3; gi++) begin : g_lut
        pgm_ram #(
            .AW (8),
            .DW (6)
        ) u_lut (
            .mclk_i  (mclk_i),
            .nrst_i  (nrst_i),
            .we_i    (s.lut_we && (s.lut_sel == 2'(gi))),
            .waddr_i (s.lut_idx),
            .wdata_i (s.lut_dat),
            .re_i    (tick),
            .raddr_i (s.pix0[7:0]),
            .rdata_o (lut_q[gi])
        );
    end

    pgm_ram #(
        .AW (6),
        .DW (6)
    ) u_shade (
        .mclk_i  (mclk_i),
        .nrst_i  (nrst_i),
        .we_i    (s.lut_we && (s.lut_sel == `PGM_SEL_SHADE)),
        .waddr_i (s.lut_idx[5:0]),
        .wdata_i (s.lut_dat),
        .re_i    (tick),
        .raddr_i (int1),
        .rdata_o (shade_q)
    );

    // panel path taken right after the lookup stage
    assign rgb1 = s.ctrl[`PGM_C_HIC] ? s.hc1 : {lut_q[2], lut_q[1], lut_q[0]};
    assign int1 = weigh(rgb1);

    assign s_axi_awready_o = !s.aw_ok && !s.bvalid;
    assign s_axi_wready_o  = !s.w_ok && !s.bvalid;
    assign s_axi_bvalid_o  = s.bvalid;
    assign s_axi_bresp_o   = s.bresp;
    assign s_axi_arready_o = !s.rvalid;
    assign s_axi_rvalid_o  = s.rvalid;
    assign s_axi_rdata_o   = s.rdata;
    assign s_axi_rresp_o   = s.rresp;

    assign panel_frame_toggle_o      = s.tog_q;
    assign panel_frame_start_pulse_o = s.frm_q;
    assign panel_line_latch_pulse_o  = s.line_q;
    assign panel_shift_clock_o       = s.sclk_q;
    assign panel_data_enable_o       = s.de_q;
    assign upper_panel_data_o        = s.dout[7:0];
    assign lower_panel_data_o        = s.dout[15:8];
    assign panel_extra_data_o        = s.dout[17:16];
    assign dac_red_o                 = s.dac_r;
    assign dac_green_o               = s.dac_g;
    assign dac_blue_o                = s.dac_b;

    // ==========================================================
    // next state
    always_comb begin
        logic [31:0] wv;
        logic        run, off, act, adv, lend, emit, bit_m;
        logic [17:0] d;
        logic [6:0]  rnd;
        wv    = '0;
        d     = '0;
        emit  = 1'b0;
        bit_m = 1'b0;
        rnd   = '0;
        n     = s;
        n.lut_we = 1'b0;
        run  = s.ctrl[`PGM_C_EN] && !s.ctrl[`PGM_C_IDLE];
        off  = !run || s.ctrl[`PGM_C_PWROFF];
        tick = run && (s.div == s.ctrl[`PGM_C_DIV]);
        n.div = tick || !run ? 4'h0 : s.div + 4'h1;
        act  = (s.hcnt < s.htim[`PGM_F_ACT]) && (s.vcnt < s.vtim[`PGM_F_ACT]);
        pop  = tick && act && f_valid;
        // a starved active pixel freezes the raster instead of tearing
        adv  = tick && (!act || f_valid);
        lend = (s.hcnt == s.htim[`PGM_F_TOT] - 12'h001);

        // ---------------- register write
        if (s_axi_awvalid_i && s_axi_awready_o) begin
            n.aw_ok  = 1'b1;
            n.awaddr = s_axi_awaddr_i;
        end
        if (s_axi_wvalid_i && s_axi_wready_o) begin
            n.w_ok  = 1'b1;
            n.wdata = s_axi_wdata_i;
            n.wstrb = s_axi_wstrb_i;
        end
        if (s.bvalid && s_axi_bready_i) begin
            n.bvalid = 1'b0;
        end
        if (s.aw_ok && s.w_ok && !s.bvalid) begin
            n.aw_ok  = 1'b0;
            n.w_ok   = 1'b0;
            n.bvalid = 1'b1;
            n.bresp  = `PGM_RESP_OK;
            case (reg_dec(s.awaddr))
                pgm_pkg::PGM_REG_CTRL: n.ctrl = merge(s.ctrl, s.wdata, s.wstrb);
                pgm_pkg::PGM_REG_POL:  n.pol = 5'(merge(32'(s.pol), s.wdata, s.wstrb));
                pgm_pkg::PGM_REG_HTIM: n.htim = merge(s.htim, s.wdata, s.wstrb);
                pgm_pkg::PGM_REG_VTIM: n.vtim = merge(s.vtim, s.wdata, s.wstrb);
                pgm_pkg::PGM_REG_LUT: begin
                    wv        = merge(32'h0000_0000, s.wdata, s.wstrb);
                    n.lut_we  = 1'b1;
                    n.lut_idx = wv[`PGM_L_IDX];
                    n.lut_sel = wv[`PGM_L_SEL];
                    n.lut_dat = wv[`PGM_L_DAT];
                end
                pgm_pkg::PGM_REG_STAT: n.bresp = `PGM_RESP_OK;
                default: n.bresp = `PGM_RESP_ERR;
            endcase
        end

        // ---------------- register read
        if (s.rvalid && s_axi_rready_i) begin
            n.rvalid = 1'b0;
        end
        if (s_axi_arvalid_i && !s.rvalid) begin
            n.rvalid = 1'b1;
            n.rresp  = `PGM_RESP_OK;
            case (reg_dec(s_axi_araddr_i))
                pgm_pkg::PGM_REG_CTRL: n.rdata = s.ctrl;
                pgm_pkg::PGM_REG_POL:  n.rdata = 32'(s.pol);
                pgm_pkg::PGM_REG_HTIM: n.rdata = s.htim;
                pgm_pkg::PGM_REG_VTIM: n.rdata = s.vtim;
                pgm_pkg::PGM_REG_LUT:  n.rdata = 32'h0000_0000;
                pgm_pkg::PGM_REG_STAT: n.rdata = {12'h000, s.vcnt, 4'h0, s.phase, s.tog, f_valid};
                default: begin
                    n.rdata = 32'h0000_0000;
                    n.rresp = `PGM_RESP_ERR;
                end
            endcase
        end

        // ---------------- raster and pipeline
        if (tick) begin
            n.v0    = pop;
            n.de0   = act;
            n.pix0  = f_data;
            n.x0    = s.hcnt[1:0];
            n.y0    = s.vcnt[1:0];
            n.line0 = adv && lend;
            n.frm0  = adv && lend && (s.vcnt == s.vtim[`PGM_F_TOT] - 12'h001);
            if (adv) begin
                n.hcnt = lend ? 12'h000 : s.hcnt + 12'h001;
                if (lend) begin
                    n.vcnt = n.frm0 ? 12'h000 : s.vcnt + 12'h001;
                end
            end
            n.v1    = s.v0;
            n.de1   = s.de0;
            n.line1 = s.line0;
            n.frm1  = s.frm0;
            n.x1    = s.x0;
            n.y1    = s.y0;
            if (s.ctrl[`PGM_C_565]) begin
                n.hc1 = {s.pix0[4:0], 1'b0, s.pix0[10:5], s.pix0[15:11], 1'b0};
            end else begin
                n.hc1 = {s.pix0[4:0], 1'b0, s.pix0[9:5], 1'b0, s.pix0[14:10], 1'b0};
            end
            n.v2    = s.v1;
            n.de2   = s.de1;
            n.line2 = s.line1;
            n.frm2  = s.frm1;
            n.x2    = s.x1;
            n.y2    = s.y1;
            n.r2    = rgb1[5:0];
            n.g2    = rgb1[11:6];
            n.b2    = rgb1[17:12];
            n.i2    = int1;
            n.de_a  = s.de2;
            if (s.frm2) begin
                n.phase = s.phase + 2'h1;
                n.tog   = !s.tog;
            end
            if (s.v2) begin
                if (!s.ctrl[`PGM_C_COLOR] && s.ctrl[`PGM_C_PWM]) begin
                    rnd  = s.ctrl[`PGM_C_ROUND] ? 7'(s.i2) + `PGM_RND_ADD : 7'(s.i2);
                    d    = rnd[6] ? 18'h0000F : 18'(rnd[5:2]);
                    emit = 1'b1;
                end else if (!s.ctrl[`PGM_C_COLOR]) begin
                    bit_m  = dith(shade_q, s.x2, s.y2, s.phase);
                    n.sr   = {s.sr[6:0], bit_m};
                    n.scnt = s.scnt + 3'h1;
                    if (s.scnt == `PGM_STN_LAST) begin
                        d    = 18'({s.sr[6:0], bit_m});
                        emit = 1'b1;
                    end
                end else if (!s.ctrl[`PGM_C_PWM]) begin
                    d    = 18'({dith(s.b2, s.x2, s.y2, s.phase),
                                dith(s.g2, s.x2, s.y2, s.phase),
                                dith(s.r2, s.x2, s.y2, s.phase)});
                    emit = 1'b1;
                end else begin
                    d    = fmt(s.r2, s.g2, s.b2,
                               s.ctrl[`PGM_C_TRUNC] ? s.ctrl[`PGM_C_WID] : 2'h0);
                    emit = 1'b1;
                end
            end
            if (emit) begin
                n.dout = d;
            end
            n.dac_r = s.r2;
            n.dac_g = s.g2;
            n.dac_b = s.b2;
        end
        if (s.line2 && tick) begin
            n.scnt = 3'h0;
        end

        // ---------------- pins with polarity, forced off
        n.sclk_q = (emit) ^ s.pol[`PGM_P_SCLK];
        n.line_q = (tick && s.line2) ^ s.pol[`PGM_P_LINE];
        n.frm_q  = (tick && s.frm2) ^ s.pol[`PGM_P_FRM];
        n.de_q   = n.de_a ^ s.pol[`PGM_P_DE];
        n.tog_q  = n.tog ^ s.pol[`PGM_P_TOG];
        if (off) begin
            n.sclk_q = 1'b0;
            n.line_q = 1'b0;
            n.frm_q  = 1'b0;
            n.de_q   = 1'b0;
            n.tog_q  = 1'b0;
            n.dout   = '0;
        end
        if (!run) begin
            n.dac_r = 6'h00;
            n.dac_g = 6'h00;
            n.dac_b = 6'h00;
        end
    end

    // ==========================================================
    // state register
    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            s      <= '0;
            s.htim <= `PGM_HTIM_RST;
            s.vtim <= `PGM_VTIM_RST;
        end else begin
            s <= n;
        end
    end
endmodule : pgm_mapper

/* tb/pgm_mapper_properties.sv */
// assertion checker of the panel mapper ports
`timescale 1ns/1ps
// ====
// bus and strobe checks
module pgm_mapper_properties (
    input wire logic        mclk_i, nrst_i, s_axi_awvalid_i, s_axi_awready_o,
    input wire logic        s_axi_wvalid_i, s_axi_wready_o, s_axi_bvalid_o, s_axi_bready_i,
    input wire logic        s_axi_arvalid_i, s_axi_arready_o, s_axi_rvalid_o, s_axi_rready_i,
    input wire logic        panel_frame_start_pulse_o, panel_line_latch_pulse_o,
    input wire logic [31:0] s_axi_rdata_o,
    input wire logic [5:0]  dac_red_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!nrst_i);
    a_write_answer: assert property (
        s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o
        |-> ##[1:2] s_axi_bvalid_o) else $error("no write answer");
    a_read_answer: assert property (
        s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o) else $error("no read answer");
    a_bvalid_held: assert property (
        s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o) else $error("bvalid dropped");
    a_rdata_held: assert property (
        s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
        else $error("read answer moved");
    a_one_read: assert property (
        s_axi_rvalid_o |-> !s_axi_arready_o) else $error("second read taken");
    a_one_write: assert property (
        s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o) else $error("second write");
    a_frame_on_line: assert property (
        panel_frame_start_pulse_o |-> panel_line_latch_pulse_o) else $error("lone frame pulse");
    a_latch_pulse: assert property (
        $rose(panel_line_latch_pulse_o) |=> !panel_line_latch_pulse_o) else $error("long latch");
    a_reset_quiet: assert property (disable iff (1'b0)
        !nrst_i |=> !s_axi_bvalid_o && !s_axi_rvalid_o && dac_red_o == 6'h00)
        else $error("busy in reset");
    c_write: cover property (s_axi_bvalid_o && s_axi_bready_i);
    c_read: cover property (s_axi_rvalid_o && s_axi_rready_i);
    c_frame: cover property (panel_frame_start_pulse_o);
endmodule : pgm_mapper_properties

bind pgm_mapper pgm_mapper_properties u_props (.*);

/* tb/pgm_panel_model.sv */
// flat panel model that latches words and counts lines per frame
`timescale 1ns/1ps
// ====
// panel
module pgm_panel_model (
    // strobes and data from the mapper
    input  wire logic        mclk_i, frm_i, line_i, sclk_i,
    input  wire logic [17:0] data_i,
    // what the panel saw
    output logic [17:0]      word_o,
    output logic [3:0]       lpf_o
);
    logic [3:0] lines = 4'h0;
    // data only counts when the shift clock says so
    always @(posedge mclk_i) begin
        if (sclk_i) word_o <= data_i;
        if (line_i) lines <= frm_i ? 4'h0 : lines + 4'h1;
        if (frm_i) lpf_o <= lines + 4'h1;
    end
endmodule : pgm_panel_model

/* tb/tb.sv */
// self-checking bench of the panel mapper
`timescale 1ns/1ps
`include "pgm_cfg.svh"
// ====
// bench
module tb;
    logic        mclk_i, nrst_i, s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i;
    logic        s_axi_arvalid_i, s_axi_rready_i, pix_valid_i, s_axi_awready_o;
    logic        s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
    logic        pix_ready_o, panel_frame_toggle_o, panel_frame_start_pulse_o;
    logic        panel_line_latch_pulse_o, panel_shift_clock_o, panel_data_enable_o;
    logic [7:0]  s_axi_awaddr_i, s_axi_araddr_i, upper_panel_data_o, lower_panel_data_o;
    logic [31:0] s_axi_wdata_i, s_axi_rdata_o, rd;
    logic [3:0]  s_axi_wstrb_i, lpf;
    logic [1:0]  s_axi_bresp_o, s_axi_rresp_o, panel_extra_data_o, rs;
    logic [5:0]  dac_red_o, dac_green_o, dac_blue_o;
    logic [15:0] pix_data_i;
    logic [17:0] word;
    int          bad_count = 0, n_tests = 0, i, refused = 0;
    logic [31:0] rst_tab [4] = '{32'h0, 32'h0, `PGM_HTIM_RST, `PGM_VTIM_RST};

    initial begin
        mclk_i = 1'b0;
        forever #10 mclk_i = ~mclk_i;
    end
    pgm_mapper dut (.*);
    pgm_panel_model pm (.mclk_i(mclk_i), .frm_i(panel_frame_start_pulse_o),
        .line_i(panel_line_latch_pulse_o), .sclk_i(panel_shift_clock_o),
        .data_i({panel_extra_data_o, lower_panel_data_o, upper_panel_data_o}),
        .word_o(word), .lpf_o(lpf));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    // one register access; the bus may answer late, only the count limits it
    task automatic acc(input bit w, input logic [7:0] a, input logic [31:0] d);
        bit         done = 0;
        logic [2:0] hs;
        @(posedge mclk_i);
        {s_axi_awaddr_i, s_axi_araddr_i, s_axi_wdata_i} <= {a, a, d};
        {s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i} <= {3{w}};
        {s_axi_arvalid_i, s_axi_rready_i} <= {2{!w}};
        for (int k = 0; k < 99 && !done; k++) begin
            @(negedge mclk_i);
            hs = {s_axi_awready_o, s_axi_wready_o, s_axi_arready_o};
            done = w ? s_axi_bvalid_o : s_axi_rvalid_o;
            {rd, rs} = w ? {32'h0, s_axi_bresp_o} : {s_axi_rdata_o, s_axi_rresp_o};
            @(posedge mclk_i);
            {s_axi_awvalid_i, s_axi_wvalid_i, s_axi_arvalid_i} <=
                {s_axi_awvalid_i, s_axi_wvalid_i, s_axi_arvalid_i} & ~hs;
        end
        {s_axi_bready_i, s_axi_rready_i} <= 2'h0;
        chk(32'(done), 32'h1);
    endtask : acc

    task automatic push(input logic [15:0] d);
        bit done = 0;
        @(posedge mclk_i);
        pix_data_i <= d;
        pix_valid_i <= 1'b1;
        for (int k = 0; k < 999 && !done; k++) begin
            @(negedge mclk_i);
            done = pix_ready_o;
            refused += !done;
            @(posedge mclk_i);
        end
        pix_valid_i <= 1'b0;
    endtask : push

    task automatic wo(input bit pan, input logic [17:0] e);
        logic [17:0] g;
        for (int k = 0; k < 999; k++) begin
            @(negedge mclk_i);
            g = pan ? {14'h0, word[3:0]} : {dac_red_o, dac_green_o, dac_blue_o};
            if (g === e) break;
        end
        chk(32'(g), 32'(e));
    endtask : wo

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : end_of_test

    initial begin
        #1000000;
        bad_count++;
        end_of_test();
    end

    // ====
    // tests
    initial begin
        {nrst_i, s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i} = 4'h0;
        {s_axi_arvalid_i, s_axi_rready_i, pix_valid_i} = 3'h0;
        {s_axi_awaddr_i, s_axi_araddr_i, s_axi_wdata_i, pix_data_i} = 64'h0;
        s_axi_wstrb_i = 4'hF;
        repeat (5) @(posedge mclk_i);
        nrst_i <= 1'b1;
        foreach (rst_tab[j]) begin
            acc(0, 8'(j * 4), 32'h0);
            chk(rd, rst_tab[j]);
        end
        acc(0, 8'h1C, 32'h0);
        chk(32'(rs), 32'h2);
        acc(1, `PGM_OFF_POL, 32'h1);
        acc(0, `PGM_OFF_POL, 32'h0);
        chk(rd, 32'h1);
        acc(1, `PGM_OFF_POL, 32'h0);
        $display("registers done");
        // small raster keeps frames short
        acc(1, `PGM_OFF_HTIM, 32'h0008_0004);
        acc(1, `PGM_OFF_VTIM, 32'h0003_0002);
        acc(1, `PGM_OFF_LUT, 32'h002A_0005);
        acc(1, `PGM_OFF_LUT, 32'h0015_0105);
        acc(1, `PGM_OFF_LUT, 32'h003F_0205);
        acc(0, `PGM_OFF_LUT, 32'h0);
        chk(rd, 32'h0);
        acc(1, `PGM_OFF_CTRL, 32'h3);
        push(16'h0005);
        wo(0, {6'h2A, 6'h15, 6'h3F});
        for (i = 0; i < 2; i++) begin
            acc(1, `PGM_OFF_CTRL, i ? 32'h9 : 32'h19);
            push(16'hFFFF);
            wo(0, {6'h3E, i ? 6'h3E : 6'h3F, 6'h3E});
        end
        // rounding first: its nibble cannot be left over from color mode
        for (i = 0; i < 2; i++) begin
            acc(1, `PGM_OFF_CTRL, i ? 32'h5 : 32'h85);
            push(16'h0005);
            wo(1, 18'((((42 * `PGM_W_RED + 21 * `PGM_W_GRN + 63 * `PGM_W_BLU) >> 8)
                + (i ? 0 : 2)) >> 2));
        end
        $display("mapping done");
        acc(1, `PGM_OFF_CTRL, 32'hF005);
        refused = 0;
        for (i = 0; i < 24; i++) push(16'h0005);
        chk(32'(refused > 0), 32'h1);
        rd = 32'h1;
        for (i = 0; i < 99 && rd[0]; i++) acc(0, `PGM_OFF_STAT, 32'h0);
        chk(rd & 32'h1, 32'h0);
        chk(32'(lpf), 32'h3);
        $display("stream done");
        acc(1, `PGM_OFF_CTRL, 32'hF025);
        for (i = 0; i < 6; i++) push(16'h0005);
        chk({13'h0, panel_shift_clock_o, panel_extra_data_o, lower_panel_data_o,
            upper_panel_data_o}, 32'h0);
        acc(1, `PGM_OFF_CTRL, 32'h41);
        repeat (3) @(posedge mclk_i);
        chk({13'h0, pix_ready_o, dac_red_o, dac_green_o, dac_blue_o}, 32'h0);
        acc(0, `PGM_OFF_CTRL, 32'h0);
        chk(rd, 32'h41);
        $display("power done");
        end_of_test();
    end
endmodule : tb
